// >>> src/lct_call_timing.sv
/*
  Call timing for all channels: forced states, delay, extension, presence and
  pulse modes, max presence with green-end synced reset, display options.
  Assumes occupancy, fault and change inputs synchronous to clk_sys; green
  inputs are asynchronous and active low.
*/
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module lct_call_timing import lct_pkg::*; #(
  parameter int NCH = 4,
  parameter int BASE_CYC = BASE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  input wire logic [NCH-1:0] occ_i,
  input wire logic [NCH-1:0] green_n_i,
  input wire logic [NCH-1:0] fault_i,
  input wire logic [NCH*8-1:0] dl_i,
  output logic [NCH-1:0] call_o,
  output logic [NCH-1:0] osc_en_o,
  output logic [NCH-1:0] tuned_o,
  output logic [NCH-1:0] chan_reset_o,
  output logic [NCH*4-1:0] sens_o,
  output logic [NCH*3-1:0] freq_o,
  output logic ind_disp_o,
  output logic dl_disp_o
);
  localparam int PRE_W = $clog2(BASE_CYC + 1);

  generate
    if (NCH < 1 || NCH > 4 || BASE_CYC < 2) begin : g_bad
      $error("lct_call_timing: NCH must be 1..4 and BASE_CYC at least 2");
    end
  endgenerate

  typedef struct packed {
    lct_ch_t [NCH-1:0] ch;
    logic [PRE_W-1:0] pre;
    logic [4:0] sub;
    logic [NCH-1:0] pg1;
    logic [NCH-1:0] pg2;
    logic [NCH-1:0] pg3;
    logic ind;
    logic dl;
    logic [CNT_W-1:0] ind_t;
    logic [CNT_W-1:0] dl_t;
    logic [31:0] rd;
  } lct_top_t;

  function automatic logic is_forced(input logic [3:0] sens);
    return (sens == SENS_CALL) || (sens == SENS_OFF);
  endfunction

  function automatic logic [CNT_W-1:0] mul10(input logic [9:0] v);
    logic [CNT_W-1:0] w;
    w = {4'h0, v};
    return (w << 3) + (w << 1);
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] base, input int i);
    return a == 4'(int'(base) + i);
  endfunction

  function automatic lct_top_t rst_state();
    lct_top_t t;
    t = '0;
    for (int i = 0; i < NCH; i++) begin
      t.ch[i].cfg = CFG_RST;
      t.ch[i].st = ST_IDLE;
      t.ch[i].osc = 1'b1;
    end
    t.pg1 = '1;
    t.pg2 = '1;
    t.pg3 = '1;
    return t;
  endfunction

  localparam lct_top_t S_RST = rst_state();

  lct_top_t s_r;
  lct_top_t s_nxt;

  always_comb begin
    logic base;
    logic tenth;
    logic occ;
    logic grn;
    logic gend;
    logic sync_eff;
    logic [7:0] dl;
    lct_ch_t c;
    base = 1'b0;
    tenth = 1'b0;
    occ = 1'b0;
    grn = 1'b0;
    gend = 1'b0;
    sync_eff = 1'b0;
    dl = 8'h00;
    c = '0;
    s_nxt = s_r;
    // One 5 ms base tick feeds the shared tenth tick
    base = (s_r.pre == PRE_W'(BASE_CYC - 1));
    tenth = base && (s_r.sub == 5'(BASES_PER_TENTH - 1)); // [R23]
    s_nxt.pre = base ? '0 : s_r.pre + 1'b1;
    if (base) begin
      s_nxt.sub = tenth ? 5'h00 : s_r.sub + 5'h01;
    end
    // Green levels cross in on two flops; third flop only for the edge
    s_nxt.pg1 = green_n_i; // [R23]
    s_nxt.pg2 = s_r.pg1;
    s_nxt.pg3 = s_r.pg2;
    // Display options time out on their own
    if (s_r.ind && tenth) begin
      s_nxt.ind_t = s_r.ind_t + 1'b1;
      if (s_r.ind_t == CNT_W'(DISP_TIMEOUT_TENTHS - 1)) begin
        s_nxt.ind = 1'b0; // [R21]
      end
    end
    if (s_r.dl && tenth) begin
      s_nxt.dl_t = s_r.dl_t + 1'b1;
      if (s_r.dl_t == CNT_W'(DISP_TIMEOUT_TENTHS - 1)) begin
        s_nxt.dl = 1'b0; // [R22]
      end
    end
    for (int i = 0; i < NCH; i++) begin
      c = s_r.ch[i];
      occ = occ_i[i];
      grn = !s_r.pg2[i];
      gend = !s_r.pg3[i] && s_r.pg2[i];
      sync_eff = c.cfg.green_end_synced_reset && (c.cfg.maxp != 10'h000); // [R19]
      dl = dl_i[i*8 +: 8];
      c.rst = 1'b0;
      if (is_forced(c.cfg.sens)) begin
        c.st = ST_IDLE; // [R1] [R2]
        c.cnt = '0;
        c.mp = '0;
      end else begin
        case (c.st)
          ST_IDLE: begin
            if (occ && c.cfg.pulse) begin
              c.st = ST_PULSE; // [R11] [R12]
              c.pt = 5'h00;
              c.mp = '0;
            end else if (occ && (grn || c.cfg.delay == 8'h00)) begin
              c.st = ST_DETECT; // [R7]
              c.mp = mul10(c.cfg.maxp); // [R15]
            end else if (occ) begin
              c.st = ST_DELAY; // [R5] [R6]
              c.cnt = mul10({2'b00, c.cfg.delay});
            end
          end
          ST_DELAY: begin
            if (!occ) begin
              c.st = ST_IDLE;
            end else if (grn || c.cnt == '0) begin
              c.st = ST_DETECT; // [R6] [R7]
              c.cnt = '0;
              c.mp = mul10(c.cfg.maxp);
            end else if (tenth) begin
              c.cnt = c.cnt - 1'b1;
            end
          end
          ST_DETECT: begin
            if (!occ) begin
              c.st = (c.cfg.ext == 8'h00) ? ST_IDLE : ST_EXTEND; // [R16] [R8]
              c.cnt = {6'h00, c.cfg.ext}; // [R9] [R10]
            end else if (c.cfg.maxp != 10'h000 && c.mp == '0) begin
              if (sync_eff) begin
                c.st = ST_WAIT; // [R18]
              end else begin
                c.st = ST_TUNED; // [R17]
                c.rst = 1'b1;
              end
            end else if (c.cfg.maxp != 10'h000 && tenth) begin
              c.mp = c.mp - 1'b1;
            end
          end
          ST_EXTEND: begin
            if (occ) begin
              c.st = ST_DETECT; // [R10]
            end else if (c.cnt == '0) begin
              c.st = ST_IDLE;
            end else if (tenth) begin
              c.cnt = c.cnt - 1'b1; // [R9]
            end
          end
          ST_WAIT: begin
            if (!occ) begin
              c.st = ST_IDLE; // [R18]
            end else if (gend && !fault_i[i]) begin
              c.st = ST_TUNED; // [R18] [R20]
              c.rst = 1'b1;
            end
          end
          ST_PULSE: begin
            if (base && c.pt != 5'(PULSE_BASES)) begin
              c.pt = c.pt + 5'h01;
            end
            if (tenth) begin
              c.mp = c.mp + 1'b1;
            end
            if (occ && c.mp >= CNT_W'(TUNE_OUT_TENTHS)) begin
              c.st = ST_TUNED; // [R13]
            end else if (!occ && c.pt == 5'(PULSE_BASES)) begin
              c.st = ST_IDLE;
            end
          end
          ST_TUNED: begin
            // Departure restores sensitivity at once, well inside 0.5 s
            if (!occ) begin
              c.st = ST_IDLE; // [R14]
            end
          end
          default: begin
            c.st = ST_IDLE;
          end
        endcase
      end
      // Peak of the change value is held 2 s during a call while the change display is on
      if (s_r.dl && c.call) begin
        if (dl > c.peak) begin
          c.peak = dl; // [R22]
          c.hold = 5'(PEAK_HOLD_TENTHS);
        end else if (tenth && c.hold != 5'h00) begin
          c.hold = c.hold - 5'h01;
        end else if (c.hold == 5'h00) begin
          c.peak = dl;
        end
      end else begin
        c.peak = 8'h00;
        c.hold = 5'h00;
      end
      // Register writes land after the timing step
      if (wr_i && hit(addr_i, REG_CFG0, i)) begin
        if (wr_data_i[CFG_SENS_LSB +: 4] <= SENS_OFF) begin
          c.cfg.sens = wr_data_i[CFG_SENS_LSB +: 4]; // [R3]
        end
        c.cfg.freq = wr_data_i[CFG_FREQ_LSB +: 3]; // [R4]
        c.cfg.pulse = wr_data_i[CFG_PULSE_BIT];
        c.cfg.green_end_synced_reset = wr_data_i[CFG_GSYNC_BIT] && (c.cfg.maxp != 10'h000);
        c.cfg.delay = wr_data_i[CFG_DELAY_LSB +: 8];
        c.cfg.ext = wr_data_i[CFG_EXT_LSB +: 8];
      end
      if (wr_i && hit(addr_i, REG_MAXP0, i)) begin
        c.cfg.maxp = (wr_data_i[9:0] > MAXP_MAX_S) ? MAXP_MAX_S : wr_data_i[9:0]; // [R15]
        if (wr_data_i[9:0] == 10'h000) begin
          c.cfg.green_end_synced_reset = 1'b0; // [R19]
        end
      end
      c.osc = !is_forced(c.cfg.sens); // [R1] [R2]
      c.tuned = (c.st == ST_TUNED);
      c.call = (c.cfg.sens == SENS_CALL) || (!is_forced(c.cfg.sens) &&
        ((c.st == ST_DETECT) || (c.st == ST_EXTEND) || (c.st == ST_WAIT) ||
        ((c.st == ST_PULSE) && c.pt != 5'(PULSE_BASES)))); // [R1] [R2] [R12]
      s_nxt.ch[i] = c;
    end
    // A write that turns an option on wins over its timeout
    if (wr_i && addr_i == REG_DISP) begin
      s_nxt.ind = wr_data_i[DISP_IND_BIT]; // [R21]
      s_nxt.dl = wr_data_i[DISP_DL_BIT]; // [R22]
      s_nxt.ind_t = '0;
      s_nxt.dl_t = '0;
    end
    s_nxt.rd = 32'h0000_0000;
    if (rd_i) begin
      if (addr_i == REG_DISP) begin
        s_nxt.rd = {30'h0, s_r.dl, s_r.ind};
      end
      for (int i = 0; i < NCH; i++) begin
        if (hit(addr_i, REG_CFG0, i)) begin
          s_nxt.rd = {s_r.ch[i].cfg.ext, s_r.ch[i].cfg.delay, 7'h00,
            s_r.ch[i].cfg.green_end_synced_reset, s_r.ch[i].cfg.pulse,
            s_r.ch[i].cfg.freq, s_r.ch[i].cfg.sens};
        end
        if (hit(addr_i, REG_MAXP0, i)) begin
          s_nxt.rd = {22'h0, s_r.ch[i].cfg.maxp};
        end
        if (hit(addr_i, REG_STATE0, i)) begin
          s_nxt.rd = {2'b00, s_r.ch[i].cnt, s_r.ch[i].peak, 1'b0, s_r.ch[i].st};
        end
        if (addr_i == REG_STATUS) begin
          s_nxt.rd[i] = s_r.ch[i].call;
          s_nxt.rd[4 + i] = s_r.ch[i].tuned;
          s_nxt.rd[8 + i] = fault_i[i];
          s_nxt.rd[12 + i] = !s_r.pg2[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_o = s_r.rd;
  assign ind_disp_o = s_r.ind;
  assign dl_disp_o = s_r.dl;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign call_o[g] = s_r.ch[g].call;
      assign osc_en_o[g] = s_r.ch[g].osc;
      assign tuned_o[g] = s_r.ch[g].tuned;
      assign chan_reset_o[g] = s_r.ch[g].rst;
      assign sens_o[g*4 +: 4] = s_r.ch[g].cfg.sens;
      assign freq_o[g*3 +: 3] = s_r.ch[g].cfg.freq;

      forced_off_a: assert property ( // [R1]
        s_r.ch[g].cfg.sens == SENS_OFF && !(wr_i && addr_i == 4'(g))
        |=> !call_o[g] && !osc_en_o[g])
        else $error("forced no-call channel shows a call");
      forced_call_a: assert property ( // [R2]
        s_r.ch[g].cfg.sens == SENS_CALL && !(wr_i && addr_i == 4'(g))
        |=> call_o[g] && !osc_en_o[g] && s_r.ch[g].st == ST_IDLE)
        else $error("forced call channel lost its call");
      sens_range_a: assert property (s_r.ch[g].cfg.sens <= SENS_OFF) // [R3]
        else $error("sensitivity code out of range");
      delay_start_a: assert property ( // [R6]
        s_r.ch[g].st == ST_IDLE && !s_r.ch[g].cfg.pulse && !is_forced(s_r.ch[g].cfg.sens)
        && occ_i[g] && s_r.pg2[g] && s_r.ch[g].cfg.delay != 8'h00
        |=> s_r.ch[g].st == ST_DELAY && !call_o[g])
        else $error("delay did not start on entry");
      green_abort_a: assert property ( // [R7]
        s_r.ch[g].st == ST_DELAY && !is_forced(s_r.ch[g].cfg.sens) && occ_i[g] && !s_r.pg2[g]
        |=> s_r.ch[g].st == ST_DETECT && call_o[g])
        else $error("green did not abort delay");
      ext_reload_a: assert property ( // [R10]
        s_r.ch[g].st == ST_DETECT && !is_forced(s_r.ch[g].cfg.sens) && !occ_i[g]
        && s_r.ch[g].cfg.ext != 8'h00
        |=> s_r.ch[g].st == ST_EXTEND && s_r.ch[g].cnt == {6'h00, $past(s_r.ch[g].cfg.ext)}
        && call_o[g])
        else $error("extension not loaded in full");
      pulse_end_a: assert property ( // [R12]
        s_r.ch[g].st == ST_PULSE && s_r.ch[g].pt == 5'(PULSE_BASES - 1)
        && s_r.pre == PRE_W'(BASE_CYC - 1) && !is_forced(s_r.ch[g].cfg.sens)
        |=> !call_o[g])
        else $error("pulse longer than its length");
      tune_out_a: assert property ( // [R13]
        s_r.ch[g].st == ST_PULSE && occ_i[g] && !is_forced(s_r.ch[g].cfg.sens)
        && s_r.ch[g].mp >= CNT_W'(TUNE_OUT_TENTHS)
        |=> s_r.ch[g].st == ST_TUNED && tuned_o[g])
        else $error("long vehicle not tuned out");
      maxp_reset_a: assert property ( // [R17]
        s_r.ch[g].st == ST_DETECT && occ_i[g] && !is_forced(s_r.ch[g].cfg.sens)
        && s_r.ch[g].cfg.maxp != 10'h000 && s_r.ch[g].mp == '0
        && !s_r.ch[g].cfg.green_end_synced_reset
        |=> chan_reset_o[g] ##1 !chan_reset_o[g])
        else $error("max presence expiry did not reset");
      sync_gate_a: assert property ( // [R19]
        s_r.ch[g].cfg.maxp == 10'h000 |-> !s_r.ch[g].cfg.green_end_synced_reset)
        else $error("green sync on with max presence off");
      fault_hold_a: assert property ( // [R20]
        s_r.ch[g].st == ST_WAIT && occ_i[g] && fault_i[g] && !is_forced(s_r.ch[g].cfg.sens)
        |=> !chan_reset_o[g] && s_r.ch[g].st == ST_WAIT)
        else $error("faulty channel reset at green end");
    end
  endgenerate
endmodule // lct_call_timing

// >>> src/lct_pkg.sv
/*
  Shared constants, field layouts and types for the per-channel call timing
  logic of a four-channel loop detector.
  Assumes a 200 MHz clk_sys and occupancy/fault levels from the loop front end.
*/
// Operation
// [R1] Forced no-call: output off, oscillator stopped
// [R2] Forced call: output on, oscillator stopped
// [R3] Nine sensitivity levels plus two forced codes
// [R4] Eight loop frequencies, three bits per channel
// [R5] Call delay 0 to 255 s, 1 s
// [R6] Delay starts on entry; call after expiry
// [R7] Active green aborts delay, remaining time zero
// [R8] Extension 0 to 25.5 s, 0.1 s
// [R9] Extension starts on clearing; call held meanwhile
// [R10] Entry during extension reloads full extension later
// [R11] Presence or pulse mode; presence holds call
// [R12] Pulse mode: one 125 ms pulse per entry
// [R13] Pulse mode: tune out after 2 s occupancy
// [R14] Pulse mode: full sensitivity within 0.5 s
// [R15] Max presence 1 to 999 s or off
// [R16] Vacant before expiry drops call, no reset
// [R17] Expiry without green sync resets channel
// [R18] Expiry with green sync waits for green end
// [R19] Green sync allowed only with max presence on
// [R20] Loop fault blocks reset at green end
// [R21] Inductance display global, off after 15 min
// [R22] Change display global, peak held 2 s
// [R23] Common tenth tick; green inputs synchronised
package lct_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BASE_TICK_MS = 5;
  localparam int BASE_CYCLES = BASE_TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int TENTH_MS = 100;
  localparam int BASES_PER_TENTH = TENTH_MS / BASE_TICK_MS;
  localparam int TENTHS_PER_S = 10;
  localparam int PULSE_MS = 125;
  localparam int PULSE_BASES = PULSE_MS / BASE_TICK_MS;
  localparam int TUNE_OUT_MS = 2000;
  localparam int TUNE_OUT_TENTHS = TUNE_OUT_MS / TENTH_MS;
  localparam int PEAK_HOLD_MS = 2000;
  localparam int PEAK_HOLD_TENTHS = PEAK_HOLD_MS / TENTH_MS;
  localparam int DISP_TIMEOUT_MIN = 15;
  localparam int DISP_TIMEOUT_TENTHS = DISP_TIMEOUT_MIN * 60 * TENTHS_PER_S;
  localparam int CNT_W = 14;
  localparam logic [9:0] MAXP_MAX_S = 10'h3E7;
  localparam logic [3:0] SENS_CALL = 4'h9;
  localparam logic [3:0] SENS_OFF = 4'hA;
  // Register word addresses
  localparam logic [3:0] REG_CFG0 = 4'h0;
  localparam logic [3:0] REG_MAXP0 = 4'h4;
  localparam logic [3:0] REG_DISP = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_STATE0 = 4'hA;
  // Config and display word fields
  localparam int CFG_SENS_LSB = 0;
  localparam int CFG_FREQ_LSB = 4;
  localparam int CFG_PULSE_BIT = 7;
  localparam int CFG_GSYNC_BIT = 8;
  localparam int CFG_DELAY_LSB = 16;
  localparam int CFG_EXT_LSB = 24;
  localparam int DISP_IND_BIT = 0;
  localparam int DISP_DL_BIT = 1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_DELAY = 7'h02, ST_DETECT = 7'h04, ST_EXTEND = 7'h08,
    ST_WAIT = 7'h10, ST_PULSE = 7'h20, ST_TUNED = 7'h40
  } lct_st_t;

  typedef struct packed {
    logic [3:0] sens;
    logic [2:0] freq;
    logic pulse;
    logic green_end_synced_reset;
    logic [7:0] delay;
    logic [7:0] ext;
    logic [9:0] maxp;
  } lct_cfg_t;

  typedef struct packed {
    lct_cfg_t cfg;
    lct_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] mp;
    logic [4:0] pt;
    logic [7:0] peak;
    logic [4:0] hold;
    logic call;
    logic osc;
    logic tuned;
    logic rst;
  } lct_ch_t;

  localparam lct_cfg_t CFG_RST = '{sens: 4'h4, freq: 3'h0, pulse: 1'b0,
    green_end_synced_reset: 1'b0, delay: 8'h00, ext: 8'h00, maxp: 10'h000};
endpackage

// >>> tb/lct_call_timing_tb.sv
/*
  Self-checking bench for the call timing block, short base tick.
  Assumes lct_pkg and lct_ctrl_model are compiled first.
*/
`timescale 1ns/1ps
module lct_call_timing_tb import lct_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rd_data_o;
  logic [3:0] occ_i = 4'h0;
  logic [3:0] fault_i = 4'h0;
  logic [3:0] green_req = 4'h0;
  logic [3:0] green_n_i;
  logic [31:0] dl_i = 32'h0;
  logic [3:0] call_o, osc_en_o, tuned_o, chan_reset_o;
  logic [15:0] sens_o;
  logic [11:0] freq_o;
  logic ind_disp_o, dl_disp_o;
  logic [31:0] d;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  // Short tick keeps a tenth at 80 cycles
  lct_call_timing #(.NCH(4), .BASE_CYC(4)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .occ_i(occ_i), .green_n_i(green_n_i), .fault_i(fault_i),
    .dl_i(dl_i), .call_o(call_o), .osc_en_o(osc_en_o), .tuned_o(tuned_o),
    .chan_reset_o(chan_reset_o), .sens_o(sens_o), .freq_o(freq_o),
    .ind_disp_o(ind_disp_o), .dl_disp_o(dl_disp_o));

  lct_ctrl_model #(.NCH(4)) i_ctrl (.clk_sys(clk_sys), .rst(rst),
    .green_req(green_req), .green_n(green_n_i));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 6000 cycles the scenarios need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cy(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task setocc(input int c, input logic v);
    @(posedge clk_sys);
    occ_i[c] <= v;
    #1;
  endtask

  task setgrn(input int c, input logic v);
    @(posedge clk_sys);
    green_req[c] <= v;
    #1;
  endtask

  function automatic logic sig(input int s, input int c);
    case (s)
      0: return call_o[c];
      1: return tuned_o[c];
      default: return chan_reset_o[c];
    endcase
  endfunction

  // Bounded wait; n holds the cycles spent
  task wt(input int s, input int c, input logic v, input int lim);
    n = 0;
    while (sig(s, c) !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task t_reset;
    rd(REG_CFG0);
    chk(d, 32'h00000004);
    chk(sens_o, 16'h4444);
    chk(osc_en_o, 4'hF);
    chk(call_o, 4'h0);
    rd(4'hE);
    chk(d, 32'h0);
  endtask

  task t_forced;
    wr(REG_CFG0, 32'h00000009);
    wt(0, 0, 1'b1, 3);
    chk(call_o[0], 1'b1);
    chk(osc_en_o[0], 1'b0);
    wr(REG_CFG0, 32'h0000000B);
    cy(2);
    chk(sens_o[3:0], 4'h9);
    wr(REG_CFG0, 32'h0000000A);
    setocc(0, 1'b1);
    cy(3);
    chk(call_o[0], 1'b0);
    chk(osc_en_o[0], 1'b0);
    setocc(0, 1'b0);
    for (int f = 0; f < 8; f++) begin
      wr(REG_CFG0, 32'h4 | (f << 4));
      cy(2);
      chk(freq_o[2:0], f[2:0]);
    end
    chk(osc_en_o[0], 1'b1);
  endtask

  task t_ext;
    wr(REG_CFG0, 32'h03000004);
    setocc(0, 1'b1);
    wt(0, 0, 1'b1, 3);
    chk(call_o[0], 1'b1);
    setocc(0, 1'b0);
    cy(100);
    chk(call_o[0], 1'b1);
    setocc(0, 1'b1);
    cy(20);
    setocc(0, 1'b0);
    wt(0, 0, 1'b0, 300);
    chk(n >= 150 && n <= 250, 1);
  endtask

  task t_delay;
    wr(REG_CFG0, 32'h00010004);
    setocc(0, 1'b1);
    wt(0, 0, 1'b1, 1000);
    chk(n >= 700 && n <= 830, 1);
    setocc(0, 1'b0);
    wt(0, 0, 1'b0, 4);
    chk(call_o[0], 1'b0);
    wr(REG_CFG0, 32'h00FF0004);
    setocc(0, 1'b1);
    cy(200);
    chk(call_o[0], 1'b0);
    setgrn(0, 1'b1);
    wt(0, 0, 1'b1, 8);
    chk(call_o[0], 1'b1);
    setgrn(0, 1'b0);
    setocc(0, 1'b0);
    wt(0, 0, 1'b0, 4);
  endtask

  task t_pulse;
    wr(REG_CFG0, 32'h00000084);
    setocc(0, 1'b1);
    wt(0, 0, 1'b1, 3);
    wt(0, 0, 1'b0, 200);
    chk(n >= 95 && n <= 101, 1);
    wt(1, 0, 1'b1, 1800);
    chk(n >= 1400 && tuned_o[0] === 1'b1, 1);
    chk(call_o[0], 1'b0);
    setocc(0, 1'b0);
    wt(1, 0, 1'b0, 3);
    chk(tuned_o[0], 1'b0);
    setocc(0, 1'b1);
    wt(0, 0, 1'b1, 3);
    chk(call_o[0], 1'b1);
    setocc(0, 1'b0);
    wt(0, 0, 1'b0, 200);
  endtask

  task t_maxp;
    wr(REG_CFG0, 32'h00000004);
    wr(REG_MAXP0, 32'h000003FF);
    rd(REG_MAXP0);
    chk(d, 32'h000003E7);
    wr(REG_MAXP0, 32'h00000001);
    setocc(0, 1'b1);
    cy(300);
    setocc(0, 1'b0);
    wt(2, 0, 1'b1, 900);
    chk(chan_reset_o[0], 1'b0);
    chk(call_o[0], 1'b0);
    setocc(0, 1'b1);
    wt(2, 0, 1'b1, 1000);
    chk(n >= 700 && chan_reset_o[0] === 1'b1, 1);
    wt(0, 0, 1'b0, 3);
    chk(call_o[0], 1'b0);
    setocc(0, 1'b0);
    wr(REG_MAXP0, 32'h0);
  endtask

  task t_gsync;
    wr(4'h5, 32'h0);
    wr(4'h1, 32'h00000104);
    rd(4'h1);
    chk(d[8], 1'b0);
    wr(4'h5, 32'h1);
    wr(4'h1, 32'h00000104);
    rd(4'h1);
    chk(d[8], 1'b1);
    setgrn(1, 1'b1);
    setocc(1, 1'b1);
    wt(2, 1, 1'b1, 1000);
    chk(chan_reset_o[1], 1'b0);
    chk(call_o[1], 1'b1);
    rd(4'hB);
    chk(d[6:0], 7'h10);
    @(posedge clk_sys);
    fault_i[1] <= 1'b1;
    setgrn(1, 1'b0);
    wt(2, 1, 1'b1, 10);
    chk(chan_reset_o[1], 1'b0);
    @(posedge clk_sys);
    fault_i[1] <= 1'b0;
    setgrn(1, 1'b1);
    cy(6);
    setgrn(1, 1'b0);
    wt(2, 1, 1'b1, 8);
    chk(chan_reset_o[1], 1'b1);
    wt(0, 1, 1'b0, 3);
    chk(call_o[1], 1'b0);
    setocc(1, 1'b0);
  endtask

  task t_disp;
    wr(REG_DISP, 32'h3);
    cy(2);
    chk({ind_disp_o, dl_disp_o}, 2'b11);
    @(posedge clk_sys);
    dl_i[7:0] <= 8'h30;
    setocc(0, 1'b1);
    cy(10);
    @(posedge clk_sys);
    dl_i[7:0] <= 8'h10;
    cy(20);
    rd(REG_STATE0);
    chk(d[15:8], 8'h30);
    rd(REG_STATUS);
    chk(d[3:0], 4'h1);
    setocc(0, 1'b0);
    wr(REG_DISP, 32'h0);
    cy(2);
    chk({ind_disp_o, dl_disp_o}, 2'b00);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_forced();
    t_ext();
    t_delay();
    t_pulse();
    t_maxp();
    t_gsync();
    t_disp();
    final_report();
  end
endmodule // lct_call_timing_tb

// >>> tb/lct_ctrl_model.sv
/*
  Controller side model: phase green outputs toward the detector, active low.
  Assumes the bench asks for green per channel, synchronous to clk_sys.
*/
`timescale 1ns/1ps
module lct_ctrl_model import lct_pkg::*; #(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NCH-1:0] green_req,
  output logic [NCH-1:0] green_n
);
  // Green changes only on the clk_sys edge, registered like a real controller output
  always @(posedge clk_sys) begin
    green_n <= rst ? '1 : ~green_req;
  end
endmodule // lct_ctrl_model
